// File: fsps_pkg.sv
// package of constants and types for the flash self-programming sequencer
package fsps_pkg;
  // control register bit positions
  localparam int unsigned CTL_SELF_PROGRAM_ENABLE = 0;
  localparam int unsigned CTL_PAGE_ERASE = 1;
  localparam int unsigned CTL_PAGE_WRITE = 2;
  localparam int unsigned CTL_READ_REENABLE = 4;
  localparam int unsigned CTL_SIGNATURE_READ = 5;
  localparam int unsigned CTL_READ_BUSY = 6;
  // apb register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_POINTER = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_COMMAND = 8'h0C;
  localparam logic [7:0] ADDR_REGION = 8'h10;
  // command codes on the command register
  localparam logic [1:0] CMD_LOAD = 2'h1;
  localparam logic [1:0] CMD_STORE = 2'h2;
  // command opening windows in cpu cycles
  localparam int unsigned LOAD_WINDOW = 3;
  localparam int unsigned STORE_WINDOW = 4;
  // flash geometry
  localparam int unsigned PAGE_WORDS = 128;
  localparam logic [15:0] STALL_REGION_BASE = 16'hF000;
  localparam logic [15:0] REGION_TOP = 16'hFFFF;
  localparam logic [15:0] BOOT_BASE_11 = 16'hFE00;
  localparam logic [15:0] BOOT_BASE_10 = 16'hFC00;
  localparam logic [15:0] BOOT_BASE_01 = 16'hF800;
  localparam logic [15:0] BOOT_BASE_00 = 16'hF000;
  // signature row map
  localparam logic [4:0] SIG_CALIB_ADDR = 5'h01;
  localparam logic [4:0] SIG_LAST_ADDR = 5'h16;
  // programming time
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned PROG_TIME_US = 4100;
  localparam int unsigned PROG_MIN_US = 3700;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * (CLK_HZ / 1000000);
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  typedef enum logic [1:0] {
    FSPS_IDLE = 2'b00,
    FSPS_ARMED = 2'b01,
    FSPS_BUSY = 2'b10
  } fsps_state_t;
endpackage : fsps_pkg

// File: fsps_prog_timer.sv
// programming duration timer for flash erase and write
`timescale 1ns/10ps
module fsps_prog_timer
  import fsps_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  output logic o_done
);
  typedef struct packed {
    logic [23:0] count;
    logic running;
    logic done;
  } fsps_timer_t;
  fsps_timer_t cur;
  fsps_timer_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    if (i_start && !cur.running) begin
      next_cur.running = 1'b1;
      next_cur.count = 24'h000000;
    end else if (cur.running) begin
      if (cur.count == 24'(CYCLES - 1)) begin
        next_cur.running = 1'b0;
        next_cur.done = 1'b1;
      end else begin
        next_cur.count = cur.count + 24'h000001;
      end
    end
  end

  // the timer deliberately ignores reset while running so a started write completes
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn && !cur.running) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_done = cur.done;
endmodule : fsps_prog_timer

// File: fsps_sequencer.sv
// flash self-programming sequencer: signature row, boot regions, erase and write control
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE1 = 8'h1E, // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h55, // arbitrary value
  parameter logic [7:0] SIG_BYTE3 = 8'hAA, // arbitrary value
  parameter logic [7:0] CALIB_BYTE = 8'h80,
  parameter logic [71:0] SERIAL_BYTES = 72'h0807060504030201_00, // arbitrary value
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_boot_size_select,
  input wire logic [15:0] i_pc,
  input wire logic [15:0] i_fetch_addr,
  input wire logic [7:0] i_flash_rdata,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic o_fetch_allow,
  output logic o_in_boot_region,
  output logic o_erase_pulse,
  output logic o_write_pulse,
  output logic o_buf_load_pulse,
  output logic o_buf_clear_pulse,
  output logic [8:0] o_page_index,
  output logic [6:0] o_word_in_page,
  output logic [15:0] o_buf_word,
  output logic [15:0] o_flash_raddr,
  output logic o_flash_rbyte
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    fsps_state_t st;
    logic [2:0] win;
    logic self_program_enable;
    logic signature_read_select;
    logic page_erase_command;
    logic page_write_command;
    logic concurrent_read_busy_flag;
    logic [16:0] flash_address_pointer;
    logic [15:0] data_word;
    logic [7:0] load_result;
    logic erase_p;
    logic write_p;
    logic load_p;
    logic clear_p;
    logic busy_stall;
  } fsps_seq_t;
  fsps_seq_t cur;
  fsps_seq_t next_cur;
  logic timer_done;
  logic wr_acc;
  logic rd_acc;

  function automatic logic [15:0] boot_base(input logic [1:0] sel);
    case (sel)
      2'b11: boot_base = BOOT_BASE_11;
      2'b10: boot_base = BOOT_BASE_10;
      2'b01: boot_base = BOOT_BASE_01;
      default: boot_base = BOOT_BASE_00;
    endcase
  endfunction : boot_base

  function automatic logic [7:0] sig_byte(input logic [16:0] ptr);
    logic [4:0] a;
    a = ptr[4:0];
    sig_byte = 8'hFF;
    if (ptr[16:5] == 12'h000) begin
      if (a == SIG_CALIB_ADDR) begin
        sig_byte = CALIB_BYTE;
      end else if (a == 5'h00) begin
        sig_byte = SIG_BYTE1;
      end else if (a == 5'h02) begin
        sig_byte = SIG_BYTE2;
      end else if (a == 5'h04) begin
        sig_byte = SIG_BYTE3;
      end else if (!a[0] && a >= 5'h06 && a <= SIG_LAST_ADDR) begin
        sig_byte = SERIAL_BYTES[8 * (4'(a[4:1]) - 4'h3) +: 8];
      end
    end
  endfunction : sig_byte

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  fsps_prog_timer #(
    .CYCLES(PROG_CYCLES_P)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_start(cur.erase_p || cur.write_p),
    .o_done(timer_done)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_cur = cur;
    next_cur.erase_p = 1'b0;
    next_cur.write_p = 1'b0;
    next_cur.load_p = 1'b0;
    next_cur.clear_p = 1'b0;
    case (cur.st)
      FSPS_IDLE: begin
        if (wr_acc && paddr == ADDR_CONTROL && pwdata[CTL_SELF_PROGRAM_ENABLE]) begin
          next_cur.self_program_enable = 1'b1;
          next_cur.signature_read_select = pwdata[CTL_SIGNATURE_READ];
          next_cur.page_erase_command = pwdata[CTL_PAGE_ERASE];
          next_cur.page_write_command = pwdata[CTL_PAGE_WRITE];
          next_cur.win = 3'h0;
          next_cur.st = FSPS_ARMED;
          if (pwdata[CTL_READ_REENABLE]) begin
            next_cur.concurrent_read_busy_flag = 1'b0;
            next_cur.clear_p = 1'b1;
            next_cur.self_program_enable = 1'b0;
            next_cur.st = FSPS_IDLE;
          end
        end
      end
      FSPS_ARMED: begin
        next_cur.win = cur.win + 3'h1;
        if (wr_acc && paddr == ADDR_COMMAND && pwdata[1:0] == CMD_LOAD
            && cur.signature_read_select) begin
          next_cur.load_result = sig_byte(cur.flash_address_pointer);
          next_cur.signature_read_select = 1'b0;
          next_cur.self_program_enable = 1'b0;
          next_cur.st = FSPS_IDLE;
        end else if (wr_acc && paddr == ADDR_COMMAND && pwdata[1:0] == CMD_STORE
                     && !cur.signature_read_select) begin
          if (cur.page_erase_command && !cur.page_write_command) begin
            next_cur.erase_p = 1'b1;
            next_cur.st = FSPS_BUSY;
          end else if (cur.page_write_command && !cur.page_erase_command) begin
            next_cur.write_p = 1'b1;
            next_cur.st = FSPS_BUSY;
          end else begin
            next_cur.load_p = 1'b1;
            next_cur.self_program_enable = 1'b0;
            next_cur.st = FSPS_IDLE;
          end
          if (next_cur.st == FSPS_BUSY) begin
            next_cur.concurrent_read_busy_flag = 1'b1;
            next_cur.busy_stall = 1'b1;
          end
        end else if ((cur.signature_read_select && cur.win == 3'(LOAD_WINDOW - 1))
                     || cur.win == 3'(STORE_WINDOW - 1)) begin
          next_cur.signature_read_select = 1'b0;
          next_cur.self_program_enable = 1'b0;
          next_cur.page_erase_command = 1'b0;
          next_cur.page_write_command = 1'b0;
          next_cur.st = FSPS_IDLE;
        end
      end
      FSPS_BUSY: begin
        if (timer_done) begin
          next_cur.self_program_enable = 1'b0;
          next_cur.page_erase_command = 1'b0;
          next_cur.page_write_command = 1'b0;
          next_cur.busy_stall = 1'b0;
          if (cur.page_write_command) begin
            next_cur.clear_p = 1'b1;
          end
          next_cur.st = FSPS_IDLE;
        end
      end
      default: next_cur.st = FSPS_IDLE;
    endcase
    if (wr_acc && paddr == ADDR_POINTER && cur.st != FSPS_BUSY) begin
      next_cur.flash_address_pointer = pwdata[16:0];
    end
    if (wr_acc && paddr == ADDR_DATA && cur.st != FSPS_BUSY) begin
      next_cur.data_word = pwdata[15:0];
    end
    if (wr_acc && paddr == ADDR_COMMAND && pwdata[1:0] == CMD_LOAD
        && !cur.signature_read_select) begin
      next_cur.load_result = i_flash_rdata;
    end
  end

  // ************************************************************
  // registers; a running erase or write survives reset
  // ************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cur <= '0;
      if (cur.st == FSPS_BUSY) begin
        cur.st <= next_cur.st;
        cur.busy_stall <= next_cur.busy_stall;
        cur.self_program_enable <= next_cur.self_program_enable;
        cur.concurrent_read_busy_flag <= 1'b1;
        cur.page_write_command <= next_cur.page_write_command;
        cur.flash_address_pointer <= cur.flash_address_pointer;
      end else begin
        cur.clear_p <= 1'b1;
      end
    end else begin
      cur <= next_cur;
    end
  end

  // ************************************************************
  // apb read mux and outputs
  // ************************************************************
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    case (paddr)
      ADDR_CONTROL: begin
        prdata[CTL_SELF_PROGRAM_ENABLE] = cur.self_program_enable;
        prdata[CTL_PAGE_ERASE] = cur.page_erase_command;
        prdata[CTL_PAGE_WRITE] = cur.page_write_command;
        prdata[CTL_SIGNATURE_READ] = cur.signature_read_select;
        prdata[CTL_READ_BUSY] = cur.concurrent_read_busy_flag;
      end
      ADDR_POINTER: prdata[16:0] = cur.flash_address_pointer;
      ADDR_DATA: prdata[7:0] = cur.load_result;
      ADDR_COMMAND: prdata = 32'h00000000;
      ADDR_REGION: prdata[15:0] = boot_base(i_boot_size_select);
      default: pslverr = psel && penable;
    endcase
    if (!rd_acc) begin
      prdata = 32'h00000000;
    end
  end

  assign pready = 1'b1;
  // fetches into the concurrent read region stall while busy
  assign o_fetch_allow = !cur.busy_stall || (i_fetch_addr >= STALL_REGION_BASE);
  assign o_in_boot_region = (i_pc >= boot_base(i_boot_size_select));
  assign o_erase_pulse = cur.erase_p;
  assign o_write_pulse = cur.write_p;
  assign o_buf_load_pulse = cur.load_p;
  assign o_buf_clear_pulse = cur.clear_p;
  assign o_page_index = cur.flash_address_pointer[16:8];
  assign o_word_in_page = cur.flash_address_pointer[7:1];
  assign o_buf_word = cur.data_word;
  assign o_flash_raddr = cur.flash_address_pointer[16:1];
  assign o_flash_rbyte = cur.flash_address_pointer[0];
endmodule : fsps_sequencer

// File: fsps_flash_model.sv
// program-memory array model answering ordinary byte reads
`timescale 1ns/10ps
module fsps_flash_model (
  input wire logic [15:0] i_addr,
  input wire logic i_byte,
  output logic [7:0] o_data
);
  // **********
  // read path
  // **********
  // content mixes both address bytes so a wrong word or byte select shows up
  assign o_data = i_addr[7:0] ^ i_addr[15:8] ^ {8{i_byte}};
endmodule : fsps_flash_model

// File: fsps_sequencer_sva.sv
// port-level checker for the flash self-programming sequencer
`timescale 1ns/10ps
module fsps_sequencer_chk
  import fsps_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_boot_size_select,
  input wire logic [15:0] i_pc,
  input wire logic [15:0] i_fetch_addr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic o_fetch_allow,
  input wire logic o_in_boot_region,
  input wire logic o_erase_pulse,
  input wire logic o_write_pulse,
  input wire logic o_buf_load_pulse,
  input wire logic [8:0] o_page_index,
  input wire logic [6:0] o_word_in_page,
  input wire logic [15:0] o_flash_raddr
);
  // **********
  // properties
  // **********
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [15:0] boot_base;
  logic cmd_store;
  // wraps modulo 2^16, so the top of flash falls out without a table
  assign boot_base = 16'h0000 - (16'h0200 << (2'd3 - i_boot_size_select));
  assign cmd_store = psel && penable && pwrite && paddr == ADDR_COMMAND
    && pwdata[1:0] == CMD_STORE;
  a_fetch_blocked: assert property (!o_fetch_allow |-> i_fetch_addr < STALL_REGION_BASE)
    else $error("fetch blocked outside concurrent region");
  a_stall_readable: assert property (i_fetch_addr >= STALL_REGION_BASE |-> o_fetch_allow)
    else $error("stalling region not readable");
  a_boot_match: assert property (o_in_boot_region == (i_pc >= boot_base))
    else $error("boot region flag wrong");
  a_page_map: assert property (o_page_index == o_flash_raddr[15:7])
    else $error("page index not pointer bits 16 to 8");
  a_word_map: assert property (o_word_in_page == o_flash_raddr[6:0])
    else $error("word in page not pointer bits 7 to 1");
  a_erase_cause: assert property (o_erase_pulse |-> $past(cmd_store))
    else $error("erase without store");
  a_write_cause: assert property (o_write_pulse |-> $past(cmd_store))
    else $error("page write without store");
  a_load_cause: assert property (o_buf_load_pulse |-> $past(cmd_store))
    else $error("buffer load without store");
  a_erase_single: assert property (o_erase_pulse |=> !o_erase_pulse [*3])
    else $error("erase pulse repeated");
  a_busy_block: assert property ((o_erase_pulse || o_write_pulse)
    && i_fetch_addr < STALL_REGION_BASE |-> !o_fetch_allow)
    else $error("concurrent region readable while busy");
  c_erase: cover property (o_erase_pulse);
  c_write: cover property (o_write_pulse);
  c_load: cover property (o_buf_load_pulse);
  c_block: cover property (!o_fetch_allow);
endmodule : fsps_sequencer_chk
bind fsps_sequencer fsps_sequencer_chk u_chk (.i_sys_clk, .i_rstn, .i_boot_size_select, .i_pc,
  .i_fetch_addr, .psel, .penable, .pwrite, .paddr, .pwdata, .o_fetch_allow, .o_in_boot_region,
  .o_erase_pulse, .o_write_pulse, .o_buf_load_pulse, .o_page_index, .o_word_in_page,
  .o_flash_raddr);

// File: tb_top.sv
// self-checking testbench for the flash self-programming sequencer
`timescale 1ns/10ps
module tb_top;
  import fsps_pkg::*;
  // **********
  // signals
  // **********
  localparam int unsigned PC_N = 20;
  localparam logic [7:0] B1 = 8'h3C, B2 = 8'h5A, B3 = 8'hC3, CAL = 8'h7E; // arbitrary values
  localparam logic [71:0] SER = 72'h1122334455667788_99; // arbitrary value
  logic i_sys_clk = 1'b0, i_rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [1:0] i_boot_size_select = 2'h0;
  logic [15:0] i_pc = 16'h0000, i_fetch_addr = 16'h0000, o_buf_word, o_flash_raddr;
  logic [7:0] paddr = 8'h00, i_flash_rdata;
  logic [31:0] pwdata = 32'h0, prdata, r, w;
  logic pready, pslverr, o_fetch_allow, o_in_boot_region, o_erase_pulse, o_write_pulse;
  logic o_buf_load_pulse, o_buf_clear_pulse, o_flash_rbyte, e;
  logic [8:0] o_page_index, pg;
  logic [6:0] o_word_in_page;
  logic [16:0] p;
  int miscompares = 0, total_checks = 0, n;
  always #10 i_sys_clk = ~i_sys_clk;
  fsps_sequencer #(.SIG_BYTE1(B1), .SIG_BYTE2(B2), .SIG_BYTE3(B3), .CALIB_BYTE(CAL),
    .SERIAL_BYTES(SER), .PROG_CYCLES_P(PC_N)) dut (.i_sys_clk, .i_rstn, .i_boot_size_select,
    .i_pc, .i_fetch_addr, .i_flash_rdata, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .o_fetch_allow, .o_in_boot_region, .o_erase_pulse, .o_write_pulse,
    .o_buf_load_pulse, .o_buf_clear_pulse, .o_page_index, .o_word_in_page, .o_buf_word,
    .o_flash_raddr, .o_flash_rbyte);
  fsps_flash_model fm (.i_addr(o_flash_raddr), .i_byte(o_flash_rbyte), .o_data(i_flash_rdata));
  // **********
  // model and tasks
  // **********
  function automatic logic [7:0] sig_exp(input int a);
    logic [7:0] q[$];
    for (int i = 0; i < 9; i++) q.push_back(SER[8*i+:8]);
    if (a == 0) return B1;
    if (a == 2) return B2;
    if (a == 4) return B3;
    if (a == 1) return CAL;
    if (a >= 6 && a <= 22 && a % 2 == 0) return q[(a-6)/2];
    return 8'hFF;
  endfunction : sig_exp
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    k = 0;
    // sampled at the rising edge itself, before the design's registers move
    do begin @(posedge i_sys_clk); k++; end while (pready !== 1'b1 && k < 50);
    r = prdata; e = pslverr;
    if (k >= 50) begin miscompares++; wrap_up(); end
  endtask : apb
  task automatic idle(input int c);
    psel <= 1'b0; penable <= 1'b0;
    repeat (c) @(posedge i_sys_clk);
  endtask : idle
  task automatic poll_done();
    n = 0;
    do begin apb(1'b0, ADDR_CONTROL, 32'h0); n++; end while (r[0] === 1'b1 && n < 200);
    if (n >= 200) begin miscompares++; wrap_up(); end
  endtask : poll_done
  initial begin repeat (50000) @(posedge i_sys_clk); miscompares++; wrap_up(); end
  // **********
  // scenarios
  // **********
  initial begin
    r = $urandom(86318);
    repeat (20) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    for (int s = 0; s < 4; s++) begin
      w = 32'h10000 - (32'd512 << (3 - s));
      i_boot_size_select <= s[1:0]; i_pc <= w[15:0];
      apb(1'b0, ADDR_REGION, 32'h0); chk(r, w, "boot base");
      chk(o_in_boot_region, 1'b1, "boot start");
      i_pc <= w[15:0] - 16'h0001; idle(1);
      chk(o_in_boot_region, 1'b0, "application end");
    end
    apb(1'b0, 8'h40, 32'h0); chk(e, 1'b1, "unmapped");
    $display("test boot done");
    p = 17'($urandom); i_fetch_addr <= 16'($urandom);
    apb(1'b1, ADDR_POINTER, {15'h0, p}); apb(1'b1, ADDR_COMMAND, CMD_LOAD);
    apb(1'b0, ADDR_DATA, 32'h0); idle(1);
    chk(r[7:0], p[8:1] ^ p[16:9] ^ {8{p[0]}}, "ordinary load");
    chk(o_page_index, p[16:8], "page index");
    chk(o_word_in_page, p[7:1], "word in page");
    apb(1'b1, ADDR_CONTROL, 32'h21); idle(4); apb(1'b0, ADDR_CONTROL, 32'h0); idle(1);
    chk(r[5] | r[0], 1'b0, "window lapse");
    w = $urandom;
    apb(1'b1, ADDR_DATA, w); apb(1'b1, ADDR_CONTROL, 32'h01);
    apb(1'b1, ADDR_COMMAND, CMD_STORE); idle(1);
    chk(o_buf_load_pulse, 1'b1, "load pulse");
    chk(o_buf_word, w[15:0], "buffer word");
    $display("test load done");
    pg = 9'($urandom); i_fetch_addr <= 16'h1000;
    apb(1'b1, ADDR_POINTER, {pg, 8'h00}); apb(1'b1, ADDR_CONTROL, 32'h03);
    apb(1'b1, ADDR_COMMAND, CMD_STORE); idle(1);
    chk(o_erase_pulse, 1'b1, "erase pulse");
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk(r[6] & r[0], 1'b1, "busy after erase");
    chk(o_fetch_allow, 1'b0, "concurrent blocked");
    chk(o_page_index, pg, "erase page");
    i_fetch_addr <= 16'hF800; idle(1);
    chk(o_fetch_allow, 1'b1, "stall readable");
    poll_done();
    chk(n * 2 >= PC_N - 4 && n * 2 <= PC_N + 4, 1'b1, "programming time");
    chk(r[6], 1'b1, "busy until reenable");
    apb(1'b1, ADDR_CONTROL, 32'h11); idle(1);
    chk(o_buf_clear_pulse, 1'b1, "buffer clear");
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk(r[6], 1'b0, "reenable");
    $display("test erase done");
    apb(1'b1, ADDR_POINTER, {pg, 8'h00}); apb(1'b1, ADDR_CONTROL, 32'h05);
    apb(1'b1, ADDR_COMMAND, CMD_STORE); idle(1);
    chk(o_write_pulse, 1'b1, "write pulse");
    // reset lands mid-write; the running write must survive it
    i_rstn <= 1'b0; repeat (2) @(posedge i_sys_clk); i_rstn <= 1'b1; @(posedge i_sys_clk);
    apb(1'b0, ADDR_CONTROL, 32'h0); chk(r[0], 1'b1, "write survives reset");
    poll_done(); apb(1'b1, ADDR_CONTROL, 32'h11); idle(1);
    $display("test write done");
    for (int a = 0; a < 24; a++) begin
      apb(1'b1, ADDR_POINTER, a); apb(1'b1, ADDR_CONTROL, 32'h21);
      apb(1'b1, ADDR_COMMAND, CMD_LOAD); apb(1'b0, ADDR_DATA, 32'h0);
      chk(r[7:0], sig_exp(a), "signature byte");
      apb(1'b0, ADDR_CONTROL, 32'h0); chk(r[5] | r[0], 1'b0, "auto clear");
    end
    idle(1);
    $display("test signature done");
    wrap_up();
  end
endmodule : tb_top
